// [testbench/cgo_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cgo_params.svh"

module cgo_regs_tb_top;
  import cgo_pkg::*;

  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        wb_cyc    = 1'b0;
  logic        wb_stb    = 1'b0;
  logic        wb_we     = 1'b0;
  logic [7:0]  wb_adr    = 8'h00;
  logic [3:0]  wb_sel    = 4'h0;
  logic [31:0] wb_dat    = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        smp_valid = 1'b0;
  cgo_smp_t    smp14     = 14'h0000;
  cgo_smp_t    smp15     = 14'h0000;
  cgo_out_t    corr14_o;
  cgo_out_t    corr15_o;
  logic        corr_valid_o;
  int          failures  = 0;
  int          checks_done = 0;
  integer      seed      = 96847;
  logic [31:0] rd;
  logic [31:0] r;
  logic        ge;
  logic        oe;
  cgo_off_t    o14;
  cgo_off_t    o15;
  cgo_smp_t    a;
  cgo_smp_t    b;
  localparam logic [5:0] IDXS [6] = '{`CGO_IDX_CFG3, `CGO_IDX_CH14_GO, `CGO_IDX_CH14_SH,
                                      `CGO_IDX_CH15_GO, `CGO_IDX_CH15_SH, `CGO_IDX_STAT};

  cgo_regs cgo_regs_inst (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wb_cyc_i     (wb_cyc),
    .wb_stb_i     (wb_stb),
    .wb_we_i      (wb_we),
    .wb_adr_i     (wb_adr),
    .wb_sel_i     (wb_sel),
    .wb_dat_i     (wb_dat),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o),
    .smp_valid_i  (smp_valid),
    .smp14_i      (smp14),
    .smp15_i      (smp15),
    .corr14_o     (corr14_o),
    .corr15_o     (corr15_o),
    .corr_valid_o (corr_valid_o)
  );

  always #25 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Checks done %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Upper data half is junk on purpose: it must be ignored
  task automatic bus(input logic w, input logic [5:0] idx, input logic [1:0] lo, input logic [3:0] sel,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= {idx, lo};
    wb_sel <= sel;
    wb_dat <= {16'hFFFF, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 16);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1)
    begin
      failures++;
      $display("CHECK FAILED at %0t: no bus ack", $time);
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    bus(1'b1, idx, 2'b00, 4'h3, d);
  endtask : wr

  task automatic rdchk(input logic [5:0] idx, input logic [1:0] lo, input logic [15:0] exp, input string what);
    bus(1'b0, idx, lo, 4'h3, 16'h0000);
    chk(rd, {16'h0000, exp}, what);
  endtask : rdchk

  // Sample launched, result looked at in its one valid cycle
  task automatic sample(input cgo_smp_t s14, input cgo_smp_t s15);
    @(posedge clk_i);
    smp_valid <= 1'b1;
    smp14     <= s14;
    smp15     <= s15;
    @(posedge clk_i);
    smp_valid <= 1'b0;
    smp14     <= ~s14;
    smp15     <= ~s15;
    @(posedge clk_i);
  endtask : sample

  task automatic reset_check(input string name);
    foreach (IDXS[i])
      rdchk(IDXS[i], 2'b00, 16'h0000, "reset value");
    chk(corr14_o, 32'h0, "corr reset");
    chk(corr15_o, 32'h0, "corr15 reset");
    chk(corr_valid_o, 32'h0, "valid reset");
    $display("Test %s done", name);
  endtask : reset_check

  function automatic cgo_out_t exp_corr(input cgo_smp_t s, input int n, input cgo_off_t off, input logic g_en,
                                        input logic o_en);
    longint g;
    longint p;
    g = g_en ? longint'($rtoi(10.0 ** (n * 0.01) * 16384.0 + 0.5)) : 64'sd16384;
    p = (longint'(s) * g) >>> 14;
    if (o_en)
      p = p + longint'(off);
    return p[15:0];
  endfunction : exp_corr

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(50 * 20000);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_check("reset");
    for (int i = 1; i < 5; i++)
    begin
      r = $random(seed);
      wr(IDXS[i], r[15:0]);
      rdchk(IDXS[i], 2'b00, r[15:0], "readback");
    end
    wr(`CGO_IDX_CFG3, 16'hFFFF);
    rdchk(`CGO_IDX_CFG3, 2'b00, 16'h1100, "cfg3 mask");
    wr(`CGO_IDX_CH14_GO, 16'h1234);
    bus(1'b1, `CGO_IDX_CH14_GO, 2'b00, 4'h1, 16'hABCD);
    bus(1'b1, `CGO_IDX_CH14_GO, 2'b00, 4'h2, 16'h5600);
    rdchk(`CGO_IDX_CH14_GO, 2'b00, 16'h56CD, "byte lanes");
    bus(1'b1, 6'h10, 2'b00, 4'h3, 16'hFFFF);
    rdchk(6'h10, 2'b00, 16'h0000, "unmapped");
    bus(1'b1, `CGO_IDX_CH14_GO, 2'b10, 4'h3, 16'h0000);
    rdchk(`CGO_IDX_CH14_GO, 2'b01, 16'h0000, "misaligned read");
    rdchk(`CGO_IDX_CH14_GO, 2'b00, 16'h56CD, "misaligned write");
    $display("Test regs done");
    for (int n = 0; n < 32; n++)
    begin
      ge = n[0];
      oe = n[1];
      r = $random(seed);
      o14 = (n == 2) ? 10'h200 : r[9:0];
      o15 = (n == 3) ? 10'h1FF : r[19:10];
      wr(`CGO_IDX_CH14_GO, {n[4:0], 1'b0, o14});
      wr(`CGO_IDX_CH14_SH, {6'h00, o14});
      wr(`CGO_IDX_CH15_GO, {5'(31 - n), 1'b0, o15});
      wr(`CGO_IDX_CH15_SH, {6'h00, o15});
      wr(`CGO_IDX_CFG3, {3'b000, ge, 3'b000, oe, 8'h00});
      rdchk(`CGO_IDX_STAT, 2'b00, {12'h000, oe, ge, 2'b00}, "status");
      r = $random(seed);
      a = (n == 6) ? 14'h1FFF : r[13:0];
      b = (n == 6) ? 14'h2000 : r[27:14];
      sample(a, b);
      chk(corr_valid_o, 32'h1, "valid");
      chk(corr14_o, exp_corr(a, n, o14, ge, oe), "ch14 corr");
      chk(corr15_o, exp_corr(b, 31 - n, o15, ge, oe), "ch15 corr");
      @(posedge clk_i);
      chk(corr_valid_o, 32'h0, "valid pulse");
    end
    $display("Test datapath done");
    wr(`CGO_IDX_CH14_SH, {6'h00, ~o14});
    rdchk(`CGO_IDX_STAT, 2'b00, 16'h000D, "ch14 mismatch");
    wr(`CGO_IDX_CH15_SH, {6'h00, ~o15});
    rdchk(`CGO_IDX_STAT, 2'b00, 16'h000F, "ch15 mismatch");
    $display("Test mismatch done");
    wr(`CGO_IDX_CH14_GO, 16'hF800);
    wr(`CGO_IDX_CFG3, 16'h1000);
    sample(14'h1000, 14'h1000);
    chk(corr14_o, exp_corr(14'h1000, 31, 10'h000, 1'b1, 1'b0), "gain step 31");
    chk(corr15_o, exp_corr(14'h1000, 0, o15, 1'b1, 1'b0), "gain step 0");
    $display("Test gain corner done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_check("midrun reset");
    stop_test();
  end
endmodule : cgo_regs_tb_top

`default_nettype wire

// [verilog/cgo_chan.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cgo_params.svh"

module cgo_chan (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Configuration and samples
  cgo_chan_if.chan  ch
);
  import cgo_pkg::*;

  // Gain factors 10^(N*0.01) in Q2.14, one per 0.2 dB step
  localparam logic [15:0] GAIN_LUT [32] = '{
    16'h4000, 16'h417E, 16'h4304, 16'h4494, 16'h462D, 16'h47CF, 16'h497B, 16'h4B32,
    16'h4CF2, 16'h4EBD, 16'h5092, 16'h5273, 16'h545E, 16'h5655, 16'h5858, 16'h5A67,
    16'h5C82, 16'h5EAA, 16'h60DE, 16'h6320, 16'h656F, 16'h67CC, 16'h6A37, 16'h6CB0,
    16'h6F38, 16'h71CF, 16'h7476, 16'h772C, 16'h79F3, 16'h7CCA, 16'h7FB2, 16'h82AC
  };

  logic signed [16:0] gain_mul;
  logic signed [30:0] prod;
  logic signed [17:0] sum;
  cgo_out_t           corr_d;
  cgo_out_t           corr_q;
  logic               valid_d;
  logic               valid_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    gain_mul = ch.gain_apply ? signed'({1'b0, GAIN_LUT[ch.gain_step]})
                             : signed'({1'b0, 16'(`CGO_GAIN_UNITY)});
    prod     = 31'(ch.smp * gain_mul);
    // Headroom: 14-bit sample times at most 2.04 plus offset fits 16 bits
    sum      = 18'(prod >>> `CGO_GAIN_FRAC)
             + (ch.offset_apply ? 18'(ch.offset_value) : 18'sh00000);
    corr_d   = ch.smp_valid ? 16'(sum) : corr_q;
    valid_d  = ch.smp_valid;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      corr_q  <= 16'sh0000;
      valid_q <= 1'b0;
    end
    else
    begin
      corr_q  <= corr_d;
      valid_q <= valid_d;
    end
  end

  assign ch.corr       = corr_q;
  assign ch.corr_valid = valid_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_gain_top_step;
    ch.smp_valid && ch.gain_apply && !ch.offset_apply && ch.gain_step == 5'h1F
      && ch.smp == 14'sh1000
    |=> ch.corr == 16'sh20AB && ch.corr_valid;
  endproperty
  a_gain_top_step: assert property (p_gain_top_step) else $error("gain step 31 wrong");

  property p_offset_add;
    ch.smp_valid && !ch.gain_apply && ch.offset_apply
    |=> ch.corr == 16'($past(ch.smp)) + 16'($past(ch.offset_value));
  endproperty
  a_offset_add: assert property (p_offset_add) else $error("offset not added signed");

  property p_offset_gated;
    ch.smp_valid && !ch.gain_apply && !ch.offset_apply
    |=> ch.corr == 16'($past(ch.smp));
  endproperty
  a_offset_gated: assert property (p_offset_gated) else $error("offset applied while off");

endmodule : cgo_chan

`default_nettype wire

// [verilog/cgo_chan_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface cgo_chan_if;
  cgo_pkg::cgo_gain_t gain_step;
  cgo_pkg::cgo_off_t  offset_value;
  logic               gain_apply;
  logic               offset_apply;
  logic               smp_valid;
  cgo_pkg::cgo_smp_t  smp;
  cgo_pkg::cgo_out_t  corr;
  logic               corr_valid;

  modport regs (output gain_step, offset_value, gain_apply, offset_apply, smp_valid, smp,
                input  corr, corr_valid);
  modport chan (input  gain_step, offset_value, gain_apply, offset_apply, smp_valid, smp,
                output corr, corr_valid);
endinterface : cgo_chan_if

`default_nettype wire

// [verilog/cgo_params.svh]
`ifndef CGO_PARAMS_SVH
`define CGO_PARAMS_SVH

// Register indices; byte address on the bus is four times the index
`define CGO_IDX_CFG3        6'h03
`define CGO_IDX_CH14_GO     6'h33
`define CGO_IDX_CH14_SH     6'h34
`define CGO_IDX_CH15_GO     6'h35
`define CGO_IDX_CH15_SH     6'h36
`define CGO_IDX_STAT        6'h3F

// Field positions
`define CGO_GAIN_MSB        15
`define CGO_GAIN_LSB        11
`define CGO_OFF_MSB         9
`define CGO_OFF_LSB         0
`define CGO_GAIN_EN_BIT     12
`define CGO_OFF_EN_BIT      8

// Status bit positions
`define CGO_ST_MISM14_BIT   0
`define CGO_ST_MISM15_BIT   1
`define CGO_ST_GAIN_BIT     2
`define CGO_ST_OFF_BIT      3

// Reset values and gain arithmetic
`define CGO_REG_RST         16'h0000
`define CGO_GAIN_UNITY      16'h4000
`define CGO_GAIN_FRAC       14

`endif

// [verilog/cgo_pkg.sv]
`default_nettype none

package cgo_pkg;

  typedef logic        [4:0]  cgo_gain_t;
  typedef logic signed [9:0]  cgo_off_t;
  typedef logic signed [13:0] cgo_smp_t;
  typedef logic signed [15:0] cgo_out_t;
  typedef logic        [15:0] cgo_reg_t;

  typedef enum {
    CGO_SEL_NONE,
    CGO_SEL_CFG3,
    CGO_SEL_CH14_GO,
    CGO_SEL_CH14_SH,
    CGO_SEL_CH15_GO,
    CGO_SEL_CH15_SH,
    CGO_SEL_STAT
  } cgo_sel_t;

endpackage : cgo_pkg

`default_nettype wire

// [verilog/cgo_regs.sv]
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "cgo_params.svh"

module cgo_regs (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Samples in
  input  wire logic              smp_valid_i,
  input  wire cgo_pkg::cgo_smp_t smp14_i,
  input  wire cgo_pkg::cgo_smp_t smp15_i,
  // Corrected samples out
  output cgo_pkg::cgo_out_t      corr14_o,
  output cgo_pkg::cgo_out_t      corr15_o,
  output logic                   corr_valid_o
);
  import cgo_pkg::*;

  function automatic cgo_sel_t cgo_decode(input logic [7:0] adr);
    cgo_sel_t sel;
    sel = CGO_SEL_NONE;
    if (adr[1:0] == 2'h0)
    begin
      case (adr[7:2])
        `CGO_IDX_CFG3:    sel = CGO_SEL_CFG3;
        `CGO_IDX_CH14_GO: sel = CGO_SEL_CH14_GO;
        `CGO_IDX_CH14_SH: sel = CGO_SEL_CH14_SH;
        `CGO_IDX_CH15_GO: sel = CGO_SEL_CH15_GO;
        `CGO_IDX_CH15_SH: sel = CGO_SEL_CH15_SH;
        `CGO_IDX_STAT:    sel = CGO_SEL_STAT;
        default:          sel = CGO_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : cgo_decode

  // Byte-lane merge of the low 16 bits
  function automatic cgo_reg_t cgo_merge(input cgo_reg_t old, input logic [31:0] dat,
                                         input logic [3:0] sel);
    cgo_reg_t v;
    v = old;
    if (sel[0])
      v[7:0] = dat[7:0];
    if (sel[1])
      v[15:8] = dat[15:8];
    return v;
  endfunction : cgo_merge

  ////////////////////////////////////////////////////////////////////////////
  // Register file: index 0 is channel 14, index 1 channel 15
  cgo_reg_t    go_q [2];
  cgo_reg_t    go_d [2];
  cgo_reg_t    sh_q [2];
  cgo_reg_t    sh_d [2];
  logic        gain_apply_q;
  logic        gain_apply_d;
  logic        offset_apply_q;
  logic        offset_apply_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic        req;
  logic        wr;
  cgo_sel_t    sel;
  logic [1:0]  mism;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = req && wb_we_i;
  assign sel = cgo_decode(wb_adr_i);

  // Copies disagree: software skipped the mirror write
  assign mism[0] = go_q[0][`CGO_OFF_MSB:`CGO_OFF_LSB] != sh_q[0][`CGO_OFF_MSB:`CGO_OFF_LSB];
  assign mism[1] = go_q[1][`CGO_OFF_MSB:`CGO_OFF_LSB] != sh_q[1][`CGO_OFF_MSB:`CGO_OFF_LSB];

  always_comb
  begin
    go_d           = go_q;
    sh_d           = sh_q;
    gain_apply_d   = gain_apply_q;
    offset_apply_d = offset_apply_q;
    ack_d          = req;
    rdat_d         = 32'h0000_0000;
    // Reserved bits of the GO and SH registers are stored as written, CFG3 drops them; software keeps them zero
    if (wr)
    begin
      case (sel)
        CGO_SEL_CFG3:
        begin
          if (wb_sel_i[1])
          begin
            gain_apply_d   = wb_dat_i[`CGO_GAIN_EN_BIT];
            offset_apply_d = wb_dat_i[`CGO_OFF_EN_BIT];
          end
        end
        CGO_SEL_CH14_GO: go_d[0] = cgo_merge(go_q[0], wb_dat_i, wb_sel_i);
        CGO_SEL_CH14_SH: sh_d[0] = cgo_merge(sh_q[0], wb_dat_i, wb_sel_i);
        CGO_SEL_CH15_GO: go_d[1] = cgo_merge(go_q[1], wb_dat_i, wb_sel_i);
        CGO_SEL_CH15_SH: sh_d[1] = cgo_merge(sh_q[1], wb_dat_i, wb_sel_i);
        default:         ;
      endcase
    end
    if (req && !wb_we_i)
    begin
      case (sel)
        CGO_SEL_CFG3:
        begin
          rdat_d[`CGO_GAIN_EN_BIT] = gain_apply_q;
          rdat_d[`CGO_OFF_EN_BIT]  = offset_apply_q;
        end
        CGO_SEL_CH14_GO: rdat_d[15:0] = go_q[0];
        CGO_SEL_CH14_SH: rdat_d[15:0] = sh_q[0];
        CGO_SEL_CH15_GO: rdat_d[15:0] = go_q[1];
        CGO_SEL_CH15_SH: rdat_d[15:0] = sh_q[1];
        CGO_SEL_STAT:
        begin
          rdat_d[`CGO_ST_MISM14_BIT] = mism[0];
          rdat_d[`CGO_ST_MISM15_BIT] = mism[1];
          rdat_d[`CGO_ST_GAIN_BIT]   = gain_apply_q;
          rdat_d[`CGO_ST_OFF_BIT]    = offset_apply_q;
        end
        default:         rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      go_q[0]        <= `CGO_REG_RST;
      go_q[1]        <= `CGO_REG_RST;
      sh_q[0]        <= `CGO_REG_RST;
      sh_q[1]        <= `CGO_REG_RST;
      gain_apply_q   <= 1'b0;
      offset_apply_q <= 1'b0;
      ack_q          <= 1'b0;
      rdat_q         <= 32'h0000_0000;
    end
    else
    begin
      go_q           <= go_d;
      sh_q           <= sh_d;
      gain_apply_q   <= gain_apply_d;
      offset_apply_q <= offset_apply_d;
      ack_q          <= ack_d;
      rdat_q         <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Channel datapaths
  cgo_chan_if ch_if [2] ();

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      assign ch_if[gi].gain_step    = go_q[gi][`CGO_GAIN_MSB:`CGO_GAIN_LSB];
      assign ch_if[gi].offset_value = signed'(go_q[gi][`CGO_OFF_MSB:`CGO_OFF_LSB]);
      assign ch_if[gi].gain_apply   = gain_apply_q;
      assign ch_if[gi].offset_apply = offset_apply_q;
      assign ch_if[gi].smp_valid    = smp_valid_i;
      assign ch_if[gi].smp          = (gi == 0) ? smp14_i : smp15_i;

      cgo_chan u_chan (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ch    (ch_if[gi])
      );
    end
  endgenerate

  assign corr14_o     = ch_if[0].corr;
  assign corr15_o     = ch_if[1].corr;
  // Both lanes strobe together; the AND keeps the second lane's flag in use
  assign corr_valid_o = ch_if[0].corr_valid && ch_if[1].corr_valid;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [15:0] wr_low;
  assign wr_low = wb_dat_i[15:0];

  sequence s_full_write(logic [7:0] a);
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == a && wb_sel_i[1:0] == 2'b11;
  endsequence

  property p_ch14_decode;
    s_full_write(8'hCC) |=> go_q[0] == $past(wr_low) ##1 wb_ack_o == 1'b0 || !wb_cyc_i;
  endproperty
  a_ch14_decode: assert property (p_ch14_decode) else $error("0x33 write not decoded");

  property p_ch14_offset;
    s_full_write(8'hCC) |=> ch_if[0].offset_value == 10'($past(wr_low)) && wb_ack_o;
  endproperty
  a_ch14_offset: assert property (p_ch14_offset) else $error("ch14 offset field wrong");

  property p_ch15_gain;
    s_full_write(8'hD4) |=> ch_if[1].gain_step == 5'($past(wr_low) >> 11);
  endproperty
  a_ch15_gain: assert property (p_ch15_gain) else $error("ch15 gain field wrong");

  property p_ch15_offset;
    s_full_write(8'hD4) |=> ch_if[1].offset_value == 10'($past(wr_low)) && go_q[0] == $past(go_q[0]);
  endproperty
  a_ch15_offset: assert property (p_ch15_offset) else $error("ch15 offset field wrong");

  property p_gain_enable;
    s_full_write(8'h0C) |=> ch_if[0].gain_apply == $past(wb_dat_i[12])
                            && ch_if[1].offset_apply == $past(wb_dat_i[8]);
  endproperty
  a_gain_enable: assert property (p_gain_enable) else $error("cfg3 enables not taken");

endmodule : cgo_regs

`default_nettype wire
